// file: src/system_address_decoder.v
// System address decoder: routes master accesses to memory targets.
// Assumes masters hold a request until granted; one clock, sync reset.
// Function
// - Decode separate 64K I/O register space
// - I/O peripherals selected by word address
// - Only listed peripherals reachable by DMA
// - Decode 16 MB unified memory space
// - First 192 bytes are registers
// - Dual RAM: 8 blocks, two accesses
// - Single RAM: 32 blocks, one access
// - SDRAM window 050000h up to 800000h
// - Four asynchronous chip-select windows
// - One select output per window
// - SDRAM uses one or two selects
// - ROM mapped unless disable bit set
// - Unmapped reads zero, writes ignored
// - USB and LCD denied dual RAM
// - All masters decoded in one pass, index 0 first
// - Hardware reset clears ROM disable
`timescale 1ns/1ps
`include "addr_decoder_defines.vh"

module system_address_decoder #(
  parameter NM = `NUM_MASTERS
) (
  input wire clock,
  input wire nrst,
  input wire [NM-1:0] req,
  input wire [NM-1:0] req_io,
  input wire [NM-1:0] req_wr,
  input wire [NM*24-1:0] req_addr,
  input wire [NM*16-1:0] req_rdata_in,
  input wire rom_disable_set,
  input wire rom_disable_clr,
  input wire sdram_dual_cs,
  output wire [NM-1:0] grant,
  output reg [NM-1:0] ack_ff,
  output reg [NM*4-1:0] target_ff,
  output reg [NM*5-1:0] periph_ff,
  output reg [NM*5-1:0] block_ff,
  output reg [NM*16-1:0] rdata_ff,
  output reg rom_disable_bit,
  output reg sdram_window_select,
  output reg sdram_secondary_select,
  output reg [3:0] async_window_selects,
  output reg [1:0] dual_access_ram_port_busy_ff
);

  // ----------------------------------------------------------------
  // Memory decode function
  // ----------------------------------------------------------------
  function [3:0] mem_target;
    input [23:0] a;
    input rom_off;
    input no_dual_access_ram;
    begin
      if (a < `MEM_MMR_END) begin
        mem_target = `TGT_MMR;
      end else if (a < `MEM_DUAL_ACCESS_RAM_END) begin
        mem_target = no_dual_access_ram ? `TGT_NONE : `TGT_DUAL_ACCESS_RAM;
      end else if (a < `MEM_SINGLE_ACCESS_RAM_END) begin
        mem_target = `TGT_SINGLE_ACCESS_RAM;
      end else if (a < `MEM_ASYNC0_BASE) begin
        mem_target = `TGT_SDRAM;
      end else if (a < `MEM_ASYNC1_BASE) begin
        mem_target = `TGT_ASYNC0;
      end else if (a < `MEM_ASYNC2_BASE) begin
        mem_target = `TGT_ASYNC1;
      end else if (a < `MEM_ASYNC3_BASE) begin
        mem_target = `TGT_ASYNC2;
      end else if (a < `MEM_ROM_BASE) begin
        mem_target = `TGT_ASYNC3;
      end else begin
        mem_target = rom_off ? `TGT_NONE : `TGT_ROM;
      end
    end
  endfunction

  wire [NM*5-1:0] io_per;
  wire [NM-1:0] io_hit;
  reg [NM*4-1:0] tgt;
  reg [NM-1:0] nxt_grant;
  reg [31:0] single_access_ram_taken;
  reg [1:0] dual_cnt [0:7];
  reg [NM-1:0] nxt_ack;
  reg [NM*16-1:0] nxt_rdata;
  reg [3:0] nxt_async;
  reg nxt_sdram;
  integer i;
  integer j;
  integer k;
  genvar g;

  // ----------------------------------------------------------------
  // Per-master I/O decode
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < NM; g = g + 1) begin : io_dec
      io_space_decoder u_io (
        .io_addr(req_addr[g*24 +: 16]),
        .from_dma(g != `MST_CPU),
        .periph(io_per[g*5 +: 5]),
        .io_hit(io_hit[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Decode and arbitration
  // ----------------------------------------------------------------
  always @* begin
    tgt = {NM*4{1'b0}};
    nxt_grant = {NM{1'b0}};
    single_access_ram_taken = 32'h00000000;
    nxt_ack = {NM{1'b0}};
    nxt_rdata = {NM*16{1'b0}};
    nxt_async = 4'h0;
    nxt_sdram = 1'b0;
    for (k = 0; k < 8; k = k + 1) begin
      dual_cnt[k] = 2'b00;
    end
    // Lower index is served first; a stalled master must hold its request
    // shared decode, index 0 first
    for (i = 0; i < NM; i = i + 1) begin
      if (req_io[i]) begin
        tgt[i*4 +: 4] = io_hit[i] ? `TGT_IO : `TGT_NONE;
      end else begin
        tgt[i*4 +: 4] = mem_target(req_addr[i*24 +: 24], rom_disable_bit,
                                   i == `MST_LCD || i == `MST_USB);
      end
      nxt_grant[i] = req[i];
      if (req[i] && tgt[i*4 +: 4] == `TGT_SINGLE_ACCESS_RAM) begin
        if (single_access_ram_taken[req_addr[i*24+13 +: 5]]) begin
          nxt_grant[i] = 1'b0;
        end else begin
          single_access_ram_taken[req_addr[i*24+13 +: 5]] = 1'b1;
        end
      end
      if (req[i] && tgt[i*4 +: 4] == `TGT_DUAL_ACCESS_RAM) begin
        if (dual_cnt[req_addr[i*24+13 +: 3]] == 2'd2) begin
          nxt_grant[i] = 1'b0;
        end else begin
          dual_cnt[req_addr[i*24+13 +: 3]] =
            dual_cnt[req_addr[i*24+13 +: 3]] + 2'd1;
        end
      end
      if (nxt_grant[i]) begin
        nxt_ack[i] = 1'b1;
        if (tgt[i*4 +: 4] != `TGT_NONE && !req_wr[i]) begin
          nxt_rdata[i*16 +: 16] = req_rdata_in[i*16 +: 16];
        end
        case (tgt[i*4 +: 4])
          `TGT_SDRAM: nxt_sdram = 1'b1;
          `TGT_ASYNC0: nxt_async[0] = 1'b1;
          `TGT_ASYNC1: nxt_async[1] = 1'b1;
          `TGT_ASYNC2: nxt_async[2] = 1'b1;
          `TGT_ASYNC3: nxt_async[3] = 1'b1;
          default: ;
        endcase
      end
    end
  end

  // Combinational so a master learns of a stall in its own cycle
  assign grant = nxt_grant;

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (!nrst) begin
      ack_ff <= {NM{1'b0}};
      target_ff <= {NM*4{1'b0}};
      periph_ff <= {NM*5{1'b0}};
      block_ff <= {NM*5{1'b0}};
      rdata_ff <= {NM*16{1'b0}};
      rom_disable_bit <= 1'b0;
      sdram_window_select <= 1'b0;
      sdram_secondary_select <= 1'b0;
      async_window_selects <= 4'h0;
      dual_access_ram_port_busy_ff <= 2'b00;
    end else begin
      ack_ff <= nxt_ack;
      target_ff <= tgt;
      periph_ff <= io_per;
      // Block index is the raw bit field, not offset from the window base
      for (j = 0; j < NM; j = j + 1) begin
        block_ff[j*5 +: 5] <= req_addr[j*24+13 +: 5];
      end
      rdata_ff <= nxt_rdata;
      // Set wins so a racing disable is never lost
      if (rom_disable_set) begin
        rom_disable_bit <= 1'b1;
      end else if (rom_disable_clr) begin
        rom_disable_bit <= 1'b0;
      end
      sdram_window_select <= nxt_sdram;
      sdram_secondary_select <= nxt_sdram & sdram_dual_cs;
      async_window_selects <= nxt_async;
      // Only block 0 is exported; enough to watch the two-port limit
      dual_access_ram_port_busy_ff <= dual_cnt[0];
    end
  end

endmodule

// file: shared/addr_decoder_defines.vh
// Constants for the system address decoder: memory and I/O windows.
// Assumes byte addresses of 24 bits and I/O word addresses of 16 bits.
`ifndef ADDR_DECODER_DEFINES_VH
`define ADDR_DECODER_DEFINES_VH

// ----------------------------------------------------------------
// Memory space, byte addresses
// ----------------------------------------------------------------
`define MEM_AW 24
`define MEM_MMR_END 24'h0000c0
`define MEM_DUAL_ACCESS_RAM_END 24'h010000
`define MEM_SINGLE_ACCESS_RAM_BASE 24'h010000
`define MEM_SINGLE_ACCESS_RAM_END 24'h050000
`define MEM_SDRAM_BASE 24'h050000
`define MEM_ASYNC0_BASE 24'h800000
`define MEM_ASYNC1_BASE 24'hc00000
`define MEM_ASYNC2_BASE 24'he00000
`define MEM_ASYNC3_BASE 24'hf00000
`define MEM_ROM_BASE 24'hfe0000
`define MEM_BLOCK_LSB 13
`define NUM_DUAL_ACCESS_RAM_BLOCKS 8
`define NUM_SINGLE_ACCESS_RAM_BLOCKS 32

// ----------------------------------------------------------------
// Target codes
// ----------------------------------------------------------------
`define TGT_W 4
`define TGT_NONE 4'h0
`define TGT_MMR 4'h1
`define TGT_DUAL_ACCESS_RAM 4'h2
`define TGT_SINGLE_ACCESS_RAM 4'h3
`define TGT_SDRAM 4'h4
`define TGT_ASYNC0 4'h5
`define TGT_ASYNC1 4'h6
`define TGT_ASYNC2 4'h7
`define TGT_ASYNC3 4'h8
`define TGT_ROM 4'h9
`define TGT_IO 4'ha

// ----------------------------------------------------------------
// I/O space, word addresses
// ----------------------------------------------------------------
`define IO_AW 16
`define IO_IDLE_END 16'h0005
`define IO_DMA0_BASE 16'h0c00
`define IO_DMA_STEP_LSB 8
`define IO_DMA_WIN_LSB 7
`define IO_EMIF_BASE 16'h1000
`define IO_EMIF_END 16'h10de
`define IO_TIMER_BASE 16'h1800
`define IO_TIMER_END 16'h18a0
`define IO_RTC_BASE 16'h1900
`define IO_RTC_END 16'h1980
`define IO_I2C_BASE 16'h1a00
`define IO_I2C_END 16'h1a6d
`define IO_UART_BASE 16'h1b00
`define IO_UART_END 16'h1b20
`define IO_SYS_BASE 16'h1c00
`define IO_SYS_END 16'h1d00
`define IO_I2S_BASE 16'h2800
`define IO_I2S_END 16'h2c00
`define IO_I2S_LEN 8'h41
`define IO_LCD_BASE 16'h2e00
`define IO_LCD_END 16'h2e41
`define IO_SPI_BASE 16'h3000
`define IO_SPI_END 16'h3010
`define IO_MMC0_BASE 16'h3a00
`define IO_MMC1_BASE 16'h3b00
`define IO_MMC_LEN 8'h80
`define IO_ANA_BASE 16'h7000
`define IO_ANA_END 16'h7100
`define IO_USB_BASE 16'h8000

// I/O peripheral codes
`define PER_W 5
`define PER_NONE 5'd0
`define PER_IDLE 5'd1
`define PER_DMA0 5'd2
`define PER_EMIF 5'd6
`define PER_TIMER 5'd7
`define PER_RTC 5'd8
`define PER_I2C 5'd9
`define PER_UART 5'd10
`define PER_SYS 5'd11
`define PER_I2S 5'd12
`define PER_LCD 5'd13
`define PER_SPI 5'd14
`define PER_MMC 5'd15
`define PER_ANA 5'd16
`define PER_USB 5'd17

// Master indices
`define NUM_MASTERS 7
`define MST_CPU 0
`define MST_LCD 5
`define MST_USB 6

`endif

// file: src/io_space_decoder.v
// I/O register space decoder: maps a word address to a peripheral code.
// Assumes combinational use by the address decoder in the same clock.
`timescale 1ns/1ps
`include "addr_decoder_defines.vh"

module io_space_decoder (
  input wire [15:0] io_addr,
  input wire from_dma,
  output reg [4:0] periph,
  output wire io_hit
);

  reg [4:0] raw;
  reg dma_ok;

  // ----------------------------------------------------------------
  // Word address decode
  // ----------------------------------------------------------------
  always @* begin
    raw = `PER_NONE;
    if (io_addr < `IO_IDLE_END) begin
      raw = `PER_IDLE;
    end else if (io_addr[15:10] == 6'h03 &&
                 io_addr[`IO_DMA_WIN_LSB] == 1'b0) begin
      raw = `PER_DMA0 + {3'b000, io_addr[9:8]};
    end else if (io_addr >= `IO_EMIF_BASE && io_addr < `IO_EMIF_END) begin
      raw = `PER_EMIF;
    end else if (io_addr >= `IO_TIMER_BASE && io_addr < `IO_TIMER_END &&
                 io_addr[5] == 1'b0) begin
      raw = `PER_TIMER;
    end else if (io_addr >= `IO_RTC_BASE && io_addr < `IO_RTC_END) begin
      raw = `PER_RTC;
    end else if (io_addr >= `IO_I2C_BASE && io_addr < `IO_I2C_END) begin
      raw = `PER_I2C;
    end else if (io_addr >= `IO_UART_BASE && io_addr < `IO_UART_END) begin
      raw = `PER_UART;
    end else if (io_addr >= `IO_SYS_BASE && io_addr < `IO_SYS_END) begin
      raw = `PER_SYS;
    end else if (io_addr >= `IO_I2S_BASE && io_addr < `IO_I2S_END &&
                 io_addr[7:0] < `IO_I2S_LEN) begin
      raw = `PER_I2S;
    end else if (io_addr >= `IO_LCD_BASE && io_addr < `IO_LCD_END) begin
      raw = `PER_LCD;
    end else if (io_addr >= `IO_SPI_BASE && io_addr < `IO_SPI_END) begin
      raw = `PER_SPI;
    end else if ((io_addr[15:8] == `IO_MMC0_BASE >> 8 ||
                  io_addr[15:8] == `IO_MMC1_BASE >> 8) &&
                 io_addr[7:0] < `IO_MMC_LEN) begin
      raw = `PER_MMC;
    end else if (io_addr >= `IO_ANA_BASE && io_addr < `IO_ANA_END) begin
      raw = `PER_ANA;
    end else if (io_addr >= `IO_USB_BASE) begin
      raw = `PER_USB;
    end
  end

  // ----------------------------------------------------------------
  // DMA reach filter
  // ----------------------------------------------------------------
  always @* begin
    case (raw)
      `PER_I2C, `PER_UART, `PER_I2S, `PER_MMC, `PER_EMIF, `PER_USB,
      `PER_ANA: dma_ok = 1'b1;
      default: dma_ok = 1'b0;
    endcase
    periph = (from_dma && !dma_ok) ? `PER_NONE : raw;
  end

  assign io_hit = (periph != `PER_NONE);

endmodule

// file: bench/mem_target_model.sv
// Target memories that answer read data for every master.
// Assumes the decoder samples read data at the edge that takes a request.
`timescale 1ns/1ps
module mem_target_model #(
  parameter NM = 7
) (
  input wire logic clock,
  input wire logic [NM-1:0] req,
  input wire logic [NM*24-1:0] req_addr,
  output logic [NM*16-1:0] req_rdata_in
);
  logic [15:0] junk_ff = 16'h1234;
  always @(posedge clock) junk_ff <= ~junk_ff + 16'h0001;
  // Idle lanes churn every cycle so stale data never passes for valid
  // targets out of reset, clocked
  always_comb
    for (int i = 0; i < NM; i++)
      req_rdata_in[i*16+:16] = req[i] ? req_addr[i*24+:16] ^ 16'h5a5a
                                      : junk_ff;
endmodule

// file: bench/addr_dec_checker.sv
// Port checks for the system address decoder.
// Assumes one clock and the synchronous active-low reset nrst.
`timescale 1ns/1ps
`include "addr_decoder_defines.vh"
module addr_dec_checker #(
  parameter NM = 7
) (
  input wire clock,
  input wire nrst,
  input wire [NM-1:0] req,
  input wire [NM-1:0] req_io,
  input wire [NM*24-1:0] req_addr,
  input wire sdram_dual_cs,
  input wire [NM-1:0] grant,
  input wire [NM-1:0] ack_ff,
  input wire [NM*4-1:0] target_ff,
  input wire [NM*5-1:0] periph_ff,
  input wire [NM*16-1:0] rdata_ff,
  input wire rom_disable_bit,
  input wire sdram_window_select,
  input wire sdram_secondary_select
);
  // ------
  // Helpers
  // ------
  wire sa0 = req_addr[23:0] >= 24'h010000 && req_addr[23:0] < 24'h050000;
  wire sa1 = req_addr[47:24] >= 24'h010000 && req_addr[47:24] < 24'h050000;
  wire same_blk = req_addr[17:13] == req_addr[41:37];
  wire [3:0] t0 = target_ff[3:0];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_take;
    req[0] && grant[0];
  endsequence
  // Answer to an I/O access that hit no reachable peripheral
  sequence s_io_idle;
    ack_ff[0] && $past(req_io[0]) && periph_ff[4:0] == `PER_NONE;
  endsequence
  take_ack_a: assert property (s_take |=> ack_ff[0])
    else $error("no ack after grant");
  ack_cause_a: assert property (
    ack_ff[0] |-> $past(req[0] && grant[0]))
    else $error("ack without grant");
  rom_reset_a: assert property ($rose(nrst) |-> !rom_disable_bit)
    else $error("rom disable set after reset");
  rom_gate_a: assert property (
    ack_ff[0] && t0 == `TGT_ROM |-> !$past(rom_disable_bit))
    else $error("rom hit while disabled");
  zero_fill_a: assert property (
    ack_ff[0] && t0 == `TGT_NONE |-> rdata_ff[15:0] == 16'h0000)
    else $error("unmapped read not zero");
  io_reserved_a: assert property (
    s_io_idle |-> t0 == `TGT_NONE && rdata_ff[15:0] == 16'h0000)
    else $error("reserved io read not zero");
  no_dual_access_ram_a: assert property (
    !(ack_ff[5] && target_ff[23:20] == `TGT_DUAL_ACCESS_RAM) &&
    !(ack_ff[6] && target_ff[27:24] == `TGT_DUAL_ACCESS_RAM))
    else $error("lcd or usb reached dual ram");
  sdram_cs_a: assert property (
    ack_ff[0] && t0 == `TGT_SDRAM |-> sdram_window_select &&
    sdram_secondary_select == $past(sdram_dual_cs))
    else $error("sdram selects wrong");
  single_access_ram_one_a: assert property (
    !(req[1:0] == 2'b11 && grant[1:0] == 2'b11 && req_io[1:0] == 2'b00 &&
    sa0 && sa1 && same_blk))
    else $error("two grants on one single ram block");
endmodule
bind system_address_decoder addr_dec_checker #(.NM(NM)) u_addr_dec_checker (
  .clock(clock),
  .nrst(nrst),
  .req(req),
  .req_io(req_io),
  .req_addr(req_addr),
  .sdram_dual_cs(sdram_dual_cs),
  .grant(grant),
  .ack_ff(ack_ff),
  .target_ff(target_ff),
  .periph_ff(periph_ff),
  .rdata_ff(rdata_ff),
  .rom_disable_bit(rom_disable_bit),
  .sdram_window_select(sdram_window_select),
  .sdram_secondary_select(sdram_secondary_select)
);

// file: bench/system_address_decoder_tb_top.sv
// Self-checking bench for the system address decoder.
// Assumes the decoder, its defines header and the target model.
`timescale 1ns/1ps
`include "addr_decoder_defines.vh"
module system_address_decoder_tb_top;
  logic clock = 1'b0;
  logic nrst, rom_disable_set, rom_disable_clr, sdram_dual_cs;
  logic [6:0] req, req_io, req_wr, grant, ack_ff;
  logic [167:0] req_addr;
  logic [111:0] req_rdata_in, rdata_ff;
  logic [27:0] target_ff;
  logic [34:0] periph_ff, block_ff;
  logic rom_disable_bit, sdram_window_select, sdram_secondary_select;
  logic [3:0] async_window_selects, t;
  logic [1:0] dual_access_ram_port_busy_ff;
  logic [4:0] p, b;
  logic [15:0] d;
  int n_errors = 0;
  int cmp_count = 0;
  always #50 clock = ~clock;
  system_address_decoder u_system_address_decoder (.*);
  mem_target_model u_mem_target_model (.*);
  // ------
  // Shared tasks
  // ------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Holds the request until granted or 8 cycles pass, then reads the registered answer
  task automatic acc(input int m, input logic io, input logic [23:0] a);
    int n;
    n = 0;
    @(negedge clock);
    req_io[m] = io;
    req_addr[m*24+:24] = a;
    req[m] = 1'b1;
    #1;
    while (grant[m] !== 1'b1 && n < 8) begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    #1;
    t = target_ff[m*4+:4];
    p = periph_ff[m*5+:5];
    b = block_ff[m*5+:5];
    d = rdata_ff[m*16+:16];
    chk(ack_ff[m], 1'b1);
    @(negedge clock) req[m] = 1'b0;
  endtask
  task automatic close_out;
    if (n_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ------
  // Scenarios
  // ------
  task automatic s_mem_map;
    logic [23:0] a[12] = '{24'h0000bf, 24'h0000c0, 24'h04ffff, 24'h050000,
      24'h7fffff, 24'h800000, 24'hbfffff, 24'hc00000, 24'he00000,
      24'hfdffff, 24'hfe0000, 24'hffffff};
    logic [3:0] e[12] = '{1, 2, 3, 4, 4, 5, 5, 6, 7, 8, 9, 9};
    for (int i = 0; i < 12; i++) begin
      acc(0, 1'b0, a[i]);
      chk(t, e[i]);
      chk(d, a[i][15:0] ^ 16'h5a5a);
      chk({sdram_window_select, async_window_selects}, (e[i] == 4) ? 16
        : (e[i] > 4 && e[i] < 9) ? 1 << (e[i] - 5) : 0);
    end
  endtask
  task automatic s_io;
    logic [23:0] a[12] = '{24'h0, 24'h5, 24'hc80, 24'hf7f, 24'h1cff,
      24'h1d00, 24'h70ff, 24'h7100, 24'h1ffff, 24'h1a00, 24'h1800, 24'h1c00};
    logic [4:0] e[12] = '{1, 0, 0, 5, 11, 0, 16, 0, 17, 9, 0, 0};
    for (int i = 0; i < 12; i++) begin
      acc(i > 8, 1'b1, a[i]);
      chk(t, e[i] != 0 ? `TGT_IO : `TGT_NONE);
      chk(p, e[i]);
      chk(d, e[i] ? a[i][15:0] ^ 16'h5a5a : 0);
    end
  endtask
  task automatic s_deny;
    for (int m = 1; m < 7; m++) begin
      acc(m, 1'b0, 24'h002000);
      chk({t, d}, m > 4 ? 20'h0 : 20'h27a5a);
      acc(m, 1'b0, 24'h012000);
      chk(t, 4'h3);
      chk(b, 24'h012000 >> `MEM_BLOCK_LSB);
    end
  endtask
  task automatic s_conflict;
    @(negedge clock);
    req_io[2:0] = 3'b000;
    req_addr[47:0] = {24'h012004, 24'h012000};
    req[1:0] = 2'b11;
    #1 chk(grant[1:0], 2'b01);
    @(negedge clock);
    req[0] = 1'b0;
    #1 chk(grant[1], 1'b1);
    @(negedge clock);
    req_addr[71:0] = {3{24'h000100}};
    req[2:0] = 3'b111;
    #1 chk(grant[2:0], 3'b011);
    @(posedge clock);
    #1 chk(dual_access_ram_port_busy_ff, 2'd2);
    @(negedge clock);
    req[2:0] = 3'b100;
    #1 chk(grant[2], 1'b1);
    @(negedge clock);
    req[2] = 1'b0;
  endtask
  task automatic s_rom;
    @(negedge clock) rom_disable_set = 1'b1;
    @(negedge clock) rom_disable_set = 1'b0;
    acc(0, 1'b0, 24'hfe0000);
    chk({rom_disable_bit, t, d}, 21'h100000);
    req_wr[0] = 1'b1;
    acc(0, 1'b0, 24'hffffff);
    chk(d, 16'h0);
    req_wr[0] = 1'b0;
    rom_disable_clr = 1'b1;
    @(negedge clock) rom_disable_clr = 1'b0;
    chk(rom_disable_bit, 1'b0);
    rom_disable_set = 1'b1;
    @(negedge clock) rom_disable_set = 1'b0;
    chk(rom_disable_bit, 1'b1);
    nrst = 1'b0;
    @(negedge clock) nrst = 1'b1;
    acc(0, 1'b0, 24'hfe0000);
    chk({rom_disable_bit, t}, 5'h9);
    sdram_dual_cs = 1'b1;
    acc(0, 1'b0, 24'h400000);
    chk(sdram_secondary_select, 1'b1);
    sdram_dual_cs = 1'b0;
  endtask
  initial begin
    {nrst, rom_disable_set, rom_disable_clr, sdram_dual_cs} = 4'h0;
    {req, req_io, req_wr} = 21'h0;
    req_addr = '0;
    repeat (12) @(posedge clock);
    @(negedge clock) nrst = 1'b1;
    s_mem_map();
    s_io();
    s_deny();
    s_conflict();
    s_rom();
    close_out();
  end
  initial begin
    #100000;
    n_errors++;
    close_out();
  end
endmodule
